// file: pls_dev.sv
/*
  Dispensing unit end: decodes command pulse lengths and drives the status wire.
  Assumes motor, fault sensors and self-check logic are on aclk and give levels or pulses.
*/
`timescale 1ns/1ps
module pls_dev
  import pls_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  pls_link_if.dev link,
  // configuration and power
  input wire logic pulse_mode,
  input wire logic power_on,
  input wire logic [31:0] interval_ticks,
  // fault sensors and self-check
  input wire logic cartridge_fault,
  input wire logic overload_fault,
  input wire logic undervoltage_fault,
  input wire logic fatal_fault,
  input wire logic selfcheck_ok,
  // motor
  input wire logic motor_done,
  input wire logic [5:0] pressure_bar,
  output logic motor_start,
  output logic motor_on,
  // indications
  output logic pulse_flash,
  output logic dash_ind,
  output logic green_led,
  output logic red_led,
  output logic [5:0] pressure_disp,
  output logic cleared_ind
);
  typedef enum {ST_OFF, ST_CHECK, ST_IDLE, ST_RUN, ST_GAP, ST_HOLD} pls_dev_st_t;

  pls_dev_st_t state;
  logic [31:0] tick_cnt;
  logic tick;
  logic cmd_lvl;
  logic cmd_prev;
  logic [TW-1:0] hi_len;
  logic [TW-1:0] tcnt;
  logic [TW-1:0] sq_cnt;
  logic sq_wave;
  logic [TW-1:0] fl_cnt;
  logic flash;
  logic [31:0] remaining;
  logic [5:0] runs_left;
  logic ovl_lat;
  logic uv_lat;
  logic ack_pend;
  logic hard_fault;
  logic any_fault;
  pls_cmd_t cmd;

  always_ff @(posedge aclk) begin
    if (!aresetn || tick_cnt == TICK_DIV - 1) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == TICK_DIV - 1);

  pls_in_filter u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .pin(link.cmd_line),
    .level(cmd_lvl)
  );

  function automatic logic in_win(input logic [TW-1:0] len, input logic [TW-1:0] nom);
    return (len >= nom - TOL_T) && (len <= nom + TOL_T);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_prev <= 1'b0;
      hi_len <= '0;
    end else begin
      cmd_prev <= cmd_lvl;
      if (!cmd_lvl) begin
        hi_len <= '0;
      end else if (tick && hi_len <= STUCK_T) begin
        hi_len <= hi_len + 1'b1;
      end
    end
  end

  always_comb begin
    cmd = CMD_NONE;
    if (cmd_prev && !cmd_lvl && pulse_mode) begin
      if (in_win(hi_len, STROKE_T)) begin
        cmd = CMD_STROKE;
      end else if (in_win(hi_len, PREFILL_T)) begin
        cmd = CMD_PREFILL;
      end else if (in_win(hi_len, ACK_T)) begin
        cmd = CMD_ACK;
      end
    end
  end

  assign hard_fault = ovl_lat || uv_lat || fatal_fault;
  assign any_fault = hard_fault || cartridge_fault;

  // latched faults; a new fault wins over the acknowledge clear
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_on) begin
      ovl_lat <= 1'b0;
      uv_lat <= 1'b0;
    end else begin
      if (state == ST_CHECK && tcnt == CHECK_T && ack_pend && selfcheck_ok && !fatal_fault) begin
        ovl_lat <= 1'b0;
        uv_lat <= 1'b0;
      end
      if (overload_fault || (state == ST_RUN && tick && tcnt == RUN_MAX_T)) begin
        ovl_lat <= 1'b1;
      end
      if (undervoltage_fault) begin
        uv_lat <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_OFF;
      tcnt <= '0;
      runs_left <= 6'h0;
      ack_pend <= 1'b0;
      motor_start <= 1'b0;
      cleared_ind <= 1'b0;
      remaining <= 32'h0;
    end else begin
      motor_start <= 1'b0;
      cleared_ind <= 1'b0;
      if (tick) begin
        tcnt <= tcnt + 1'b1;
      end
      if (!power_on) begin
        state <= ST_OFF;
        ack_pend <= 1'b0;
      end else begin
        case (state)
          ST_OFF: begin
            state <= ST_CHECK;
            tcnt <= '0;
          end
          ST_CHECK: begin
            if (tcnt == CHECK_T) begin
              cleared_ind <= ack_pend && selfcheck_ok && !fatal_fault;
              ack_pend <= 1'b0;
              state <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            if (!pulse_mode) begin
              if (remaining == 32'h0) begin
                remaining <= interval_ticks;
              end else if (tick && !any_fault) begin
                remaining <= remaining - 32'h1;
                if (remaining == 32'h1) begin
                  state <= ST_RUN;
                  motor_start <= 1'b1;
                  runs_left <= 6'h0;
                  tcnt <= '0;
                end
              end
            end else if (cmd == CMD_ACK) begin
              ack_pend <= 1'b1;
              state <= ST_CHECK;
              tcnt <= '0;
            end else if (cmd != CMD_NONE && !any_fault) begin
              state <= ST_RUN;
              motor_start <= 1'b1;
              tcnt <= '0;
              runs_left <= (cmd == CMD_PREFILL) ? PREFILL_RUNS - 6'h1 : 6'h0;
            end
          end
          ST_RUN: begin
            // wait for motor, 17 s cap
            if (hard_fault) begin
              state <= ST_IDLE;
            end else if (motor_done) begin
              tcnt <= '0;
              remaining <= 32'h0;
              if (runs_left != 6'h0) begin
                state <= ST_GAP;
              end else begin
                state <= pulse_mode ? ST_HOLD : ST_IDLE;
              end
            end
          end
          ST_GAP: begin
            if (tcnt == GAP_T) begin
              state <= ST_RUN;
              motor_start <= 1'b1;
              runs_left <= runs_left - 6'h1;
              tcnt <= '0;
            end
          end
          ST_HOLD: begin
            if (tcnt > READY_T) begin
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_OFF;
          end
        endcase
      end
    end
  end

  // half hertz square wave
  // runs for every fault so the red light blinks; only the cartridge fault puts it on the wire
  always_ff @(posedge aclk) begin
    if (!aresetn || !any_fault) begin
      sq_cnt <= '0;
      sq_wave <= 1'b0;
    end else if (tick) begin
      if (sq_cnt == SQUARE_T - 1'b1) begin
        sq_cnt <= '0;
        sq_wave <= !sq_wave;
      end else begin
        sq_cnt <= sq_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !cmd_lvl) begin
      fl_cnt <= '0;
      flash <= 1'b0;
    end else if (tick) begin
      fl_cnt <= (fl_cnt == FLASH_T) ? '0 : fl_cnt + 1'b1;
      flash <= (fl_cnt == FLASH_T) ? !flash : flash;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.status_line <= 1'b0;
    end else if (state == ST_OFF || !power_on) begin
      link.status_line <= 1'b0;
    end else if (cartridge_fault) begin
      link.status_line <= sq_wave;
    end else if (hard_fault || state == ST_RUN || state == ST_CHECK) begin
      link.status_line <= 1'b0;
    end else begin
      link.status_line <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_on <= 1'b0;
      green_led <= 1'b0;
      red_led <= 1'b0;
      pulse_flash <= 1'b0;
      dash_ind <= 1'b0;
      pressure_disp <= 6'h0;
    end else begin
      motor_on <= (state == ST_RUN) && power_on;
      green_led <= (state == ST_RUN);
      red_led <= any_fault && power_on && sq_wave;
      pulse_flash <= pulse_mode && cmd_lvl && !flash;
      dash_ind <= pulse_mode && cmd_lvl && (hi_len > STUCK_T);
      if (state == ST_RUN) begin
        pressure_disp <= (pressure_bar < BAR_MIN) ? BAR_MIN : (pressure_bar > BAR_MAX) ? BAR_MAX : pressure_bar;
      end else begin
        pressure_disp <= 6'h0;
      end
    end
  end
endmodule

// file: pls_in_filter.sv
/*
  Two-flop synchroniser and tick-based debouncer for one link wire.
  Assumes tick is a one-cycle enable from the owner's time base.
*/
`timescale 1ns/1ps
module pls_in_filter
  import pls_pkg::*;
#(
  parameter int DEB = DEB_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // time base
  input wire logic tick,
  // wire in, clean level out
  input wire logic pin,
  output logic level
);
  logic sync1;
  logic sync2;
  logic [3:0] stable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // same delay on both edges, so the measured length is preserved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= 1'b0;
      stable <= 4'h0;
    end else if (sync2 == level) begin
      stable <= 4'h0;
    end else if (tick) begin
      if (stable == 4'(DEB - 1)) begin
        level <= sync2;
        stable <= 4'h0;
      end else begin
        stable <= stable + 4'h1;
      end
    end
  end
endmodule

// file: pls_link_if.sv
/*
  The two wires between the dispensing unit and its controller.
  Assumes both ends sit on the same aclk; each end still synchronises what it samples.
*/
`timescale 1ns/1ps
interface pls_link_if;
  logic cmd_line;
  logic status_line;
  modport dev (input cmd_line, output status_line);
  modport plc (output cmd_line, input status_line);
endinterface

// file: pls_link_sva.sv
/*
  Link checker: timing of the command and status wires between controller and unit.
  Assumes it sits beside the interface on the shared aclk, with the same TICK_DIV as both ends.
*/
`timescale 1ns/1ps
module pls_link_sva
  import pls_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link wires
  input wire logic cmd_line,
  input wire logic status_line
);
  localparam int unsigned S_C = STROKE_T * TICK_DIV;
  localparam int unsigned P_C = PREFILL_T * TICK_DIV;
  localparam int unsigned A_C = ACK_T * TICK_DIV;
  localparam int unsigned R_C = READY_T * TICK_DIV;
  localparam int unsigned Z_C = PAUSE_T * TICK_DIV;
  localparam int unsigned SAT = 32'h00FF_FFFF;
  int unsigned hi_len;
  int unsigned lo_len;
  int unsigned st_hi;

  always_ff @(posedge aclk) begin
    if (!aresetn || !cmd_line) begin
      hi_len <= 0;
    end else begin
      hi_len <= hi_len + 1;
    end
  end
  // starts saturated: the first command after reset owes no pause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_len <= SAT;
    end else if (cmd_line) begin
      lo_len <= 0;
    end else if (lo_len < SAT) begin
      lo_len <= lo_len + 1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !status_line) begin
      st_hi <= 0;
    end else if (st_hi < SAT) begin
      st_hi <= st_hi + 1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence stroke_end_s;
    $fell(cmd_line) && hi_len == S_C ##0 status_line;
  endsequence
  sequence ack_end_s;
    $fell(cmd_line) && hi_len == A_C && !status_line;
  endsequence

  cmd_len_a: assert property ($fell(cmd_line) |-> hi_len inside {S_C, P_C, A_C})
    else $error("command pulse length is not one of the three codes");
  cmd_max_a: assert property (cmd_line |-> hi_len < A_C)
    else $error("command wire high past the longest code");
  // one tick of slack for the tick alignment of the rising edge
  pause_kept_a: assert property ($rose(cmd_line) |-> lo_len + TICK_DIV >= Z_C)
    else $error("command pulse sent before the pause ran out");
  ready_wait_a: assert property ($rose(cmd_line) && status_line |-> st_hi > R_C)
    else $error("command sent before status was high long enough");
  run_start_a: assert property (stroke_end_s |-> ##[1:40] !status_line)
    else $error("status did not drop after a stroke pulse");
  ack_check_a: assert property (ack_end_s |-> !status_line [*8])
    else $error("status rose before the self check after acknowledge");
  reset_status_a: assert property ($rose(aresetn) |-> !status_line [*8])
    else $error("status high during the self check after reset");
  reset_cmd_a: assert property ($rose(aresetn) |-> !cmd_line [*8])
    else $error("command wire active right after reset");
endmodule

// file: pls_pkg.sv
/*
  Shared constants and types for the pulse-length command and status link.
  Assumes a single 40 MHz clock and a 10 ms internal time base on both ends.
*/
package pls_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TW = 12;

  // times in milliseconds
  localparam int unsigned STROKE_MS = 2000;
  localparam int unsigned PREFILL_MS = 12000;
  localparam int unsigned ACK_MS = 14000;
  localparam int unsigned TOL_MS = 100;
  localparam int unsigned STUCK_MS = 15000;
  localparam int unsigned READY_MS = 3000;
  localparam int unsigned GAP_MS = 500;
  localparam int unsigned PAUSE_MS = 22000;
  localparam int unsigned SQUARE_HALF_MS = 1000;
  localparam int unsigned RUN_MAX_MS = 17000;
  localparam int unsigned CHECK_MS = 200;
  localparam int unsigned FLASH_HALF_MS = 250;

  function automatic logic [TW-1:0] ms2t(input int unsigned ms);
    return TW'(ms / TICK_MS);
  endfunction

  localparam logic [TW-1:0] STROKE_T = ms2t(STROKE_MS);
  localparam logic [TW-1:0] PREFILL_T = ms2t(PREFILL_MS);
  localparam logic [TW-1:0] ACK_T = ms2t(ACK_MS);
  localparam logic [TW-1:0] TOL_T = ms2t(TOL_MS);
  localparam logic [TW-1:0] STUCK_T = ms2t(STUCK_MS);
  localparam logic [TW-1:0] READY_T = ms2t(READY_MS);
  localparam logic [TW-1:0] GAP_T = ms2t(GAP_MS);
  localparam logic [TW-1:0] PAUSE_T = ms2t(PAUSE_MS);
  localparam logic [TW-1:0] SQUARE_T = ms2t(SQUARE_HALF_MS);
  localparam logic [TW-1:0] RUN_MAX_T = ms2t(RUN_MAX_MS);
  localparam logic [TW-1:0] CHECK_T = ms2t(CHECK_MS);
  localparam logic [TW-1:0] FLASH_T = ms2t(FLASH_HALF_MS);

  localparam int DEB_TICKS = 2;
  localparam logic [5:0] PREFILL_RUNS = 6'h28;
  localparam logic [5:0] BAR_MIN = 6'h01;
  localparam logic [5:0] BAR_MAX = 6'h32;

  typedef enum logic [1:0] {CMD_NONE, CMD_STROKE, CMD_PREFILL, CMD_ACK} pls_cmd_t;

  // controller register map (AXI4-Lite, byte addresses)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LEVEL = 1;
  localparam int STAT_READY = 2;
  localparam int STAT_REFUSED = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: pls_plc.sv
/*
  Controller end: takes commands over AXI4-Lite and sends timed pulses on the command wire.
  Assumes software polls the status register; one write and one read at a time.
*/
`timescale 1ns/1ps
module pls_plc
  import pls_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link
  pls_link_if.plc link
);
  typedef enum {H_IDLE, H_WAIT, H_PULSE} pls_plc_st_t;

  pls_plc_st_t state;
  logic [31:0] tick_cnt;
  logic tick;
  logic stat_lvl;
  logic [TW-1:0] high_cnt;
  logic [TW-1:0] pause_cnt;
  logic [TW-1:0] len_cnt;
  logic [TW-1:0] target;
  pls_cmd_t cmd;
  logic refused;
  logic aw_ok;
  logic w_ok;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_strb0;
  logic wr_do;
  logic cmd_wr;
  logic ready;

  always_ff @(posedge aclk) begin
    if (!aresetn || tick_cnt == TICK_DIV - 1) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == TICK_DIV - 1);

  pls_in_filter u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .pin(link.status_line),
    .level(stat_lvl)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !stat_lvl) begin
      high_cnt <= '0;
    end else if (tick && high_cnt <= READY_T) begin
      high_cnt <= high_cnt + 1'b1;
    end
  end
  assign ready = (high_cnt > READY_T);

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_ok && !s_axi_bvalid;
  assign s_axi_wready = !w_ok && !s_axi_bvalid;
  assign wr_do = aw_ok && w_ok && !s_axi_bvalid;
  // strobe is held with the data beat, since the master may drop wvalid before the address arrives
  assign cmd_wr = wr_do && aw_addr == REG_CMD && w_strb0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      if (s_axi_araddr == REG_CMD) begin
        s_axi_rdata <= {30'h0, cmd};
      end else if (s_axi_araddr == REG_STAT) begin
        s_axi_rdata[STAT_BUSY] <= (state != H_IDLE);
        s_axi_rdata[STAT_LEVEL] <= stat_lvl;
        s_axi_rdata[STAT_READY] <= ready;
        s_axi_rdata[STAT_REFUSED] <= refused;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= H_IDLE;
      cmd <= CMD_NONE;
      target <= '0;
      len_cnt <= '0;
      pause_cnt <= PAUSE_T;
      refused <= 1'b0;
      link.cmd_line <= 1'b0;
    end else begin
      if (tick && pause_cnt < PAUSE_T) begin
        pause_cnt <= pause_cnt + 1'b1;
      end
      case (state)
        H_IDLE: begin
          if (cmd_wr && w_data[1:0] != 2'h0) begin
            cmd <= pls_cmd_t'(w_data[1:0]);
            target <= (w_data[1:0] == 2'h1) ? STROKE_T : (w_data[1:0] == 2'h2) ? PREFILL_T : ACK_T;
            refused <= 1'b0;
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (pause_cnt >= PAUSE_T && (ready || cmd == CMD_ACK) && tick) begin
            link.cmd_line <= 1'b1;
            len_cnt <= '0;
            state <= H_PULSE;
          end
        end
        H_PULSE: begin
          if (tick) begin
            if (len_cnt == target - 1'b1) begin
              link.cmd_line <= 1'b0;
              pause_cnt <= '0;
              state <= H_IDLE;
            end else begin
              len_cnt <= len_cnt + 1'b1;
            end
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
      if (cmd_wr && state != H_IDLE) begin
        refused <= 1'b1;
      end
    end
  end
endmodule

// file: testbench.sv
/*
  Testbench: controller and unit joined by one link, plus a second unit whose wire the bench drives.
  Assumes TICK_DIV of 4, so one 10 ms tick is 4 cycles of aclk.
*/
`timescale 1ns/1ps
module testbench
  import pls_pkg::*;
;
  localparam int unsigned TD = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, iv = 32'h32;
  logic pm = 1'b1, pw = 1'b1, cf = 1'b0, of = 1'b0, uf = 1'b0, ff = 1'b0, sok = 1'b1;
  logic [5:0] pb = 6'h00;
  logic [1:0] md = 2'h0;
  logic pfq = 1'b0, flash2 = 1'b0, done2 = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp, ms, mo, pf, dsh, grn, red, clr;
  wire [31:0] rdata;
  wire [5:0] pd0, pd1;
  int mcnt [2] = '{0, 0};
  int nst [2] = '{0, 0};
  int mismatches = 0, checks_done = 0, cyc = 0;

  pls_link_if link ();
  pls_link_if link2 ();
  pls_plc #(.TICK_DIV(TD)) pls_plc_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link)
  );
  pls_dev #(.TICK_DIV(TD)) pls_dev_i (
    .aclk(aclk), .aresetn(aresetn), .link(link), .pulse_mode(pm), .power_on(pw), .interval_ticks(iv),
    .cartridge_fault(cf), .overload_fault(of), .undervoltage_fault(uf), .fatal_fault(ff), .selfcheck_ok(sok),
    .motor_done(md[0]), .pressure_bar(pb), .motor_start(ms[0]), .motor_on(mo[0]), .pulse_flash(pf[0]),
    .dash_ind(dsh[0]), .green_led(grn[0]), .red_led(red[0]), .pressure_disp(pd0), .cleared_ind(clr[0])
  );
  // second unit: the bench stands in for the controller and may break the pulse rules
  pls_dev #(.TICK_DIV(TD)) pls_dev_i2 (
    .aclk(aclk), .aresetn(aresetn), .link(link2), .pulse_mode(pm), .power_on(pw), .interval_ticks(iv),
    .cartridge_fault(1'b0), .overload_fault(1'b0), .undervoltage_fault(1'b0), .fatal_fault(1'b0),
    .selfcheck_ok(sok), .motor_done(md[1]), .pressure_bar(pb), .motor_start(ms[1]), .motor_on(mo[1]),
    .pulse_flash(pf[1]), .dash_ind(dsh[1]), .green_led(grn[1]), .red_led(red[1]), .pressure_disp(pd1),
    .cleared_ind(clr[1])
  );
  pls_link_sva #(.TICK_DIV(TD)) pls_link_sva_i (
    .aclk(aclk), .aresetn(aresetn), .cmd_line(link.cmd_line), .status_line(link.status_line)
  );

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // handshakes are judged at the rising edge; a channel is released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      b = bvalid;
      r = bresp;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic v;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      v = rvalid;
      d = rdata;
      r = rresp;
    end
    rready <= 1'b0;
  endtask

  task automatic half(output int n);
    logic s;
    s = link.status_line;
    n = 0;
    while (link.status_line === s && n < 2000) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // a gap of 2200 * TD keeps the pause and the ready wait; the glitch and lockout calls use 1 and 4
  task automatic pulse2(input int n, input int gap);
    repeat (gap) @(posedge aclk);
    link2.cmd_line <= 1'b1;
    repeat (n) @(posedge aclk);
    link2.cmd_line <= 1'b0;
    repeat (20 * TD) @(posedge aclk);
  endtask

  // ceiling well above the roughly 50k cycles the scenarios need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      close_out;
    end
  end

  // motor stand-in with short random run times, plus display watch
  always @(posedge aclk) begin
    if (cyc == 0) void'($urandom(88));
    for (int i = 0; i < 2; i++) begin
      md[i] <= 1'b0;
      if (mcnt[i] > 0) begin
        mcnt[i] <= mcnt[i] - 1;
        if (mcnt[i] == 1) md[i] <= 1'b1;
      end else if (ms[i] === 1'b1) begin
        mcnt[i] <= 80 + $urandom_range(80);
        nst[i] <= nst[i] + 1;
      end
    end
    pb <= 6'($urandom_range(63));
    pfq <= pf[1];
    if (link2.cmd_line === 1'b1 && pf[1] !== pfq) flash2 <= 1'b1;
    if (mo[0] === 1'b1) chk(grn[0] === 1'b1 && pd0 >= 6'h01 && pd0 <= 6'h32, "run display");
  end

  initial begin
    int k;
    link2.cmd_line <= 1'b0;
    repeat (340 * TD + 3) @(posedge aclk);
    pulse2(1, 1);
    chk(nst[1] == 0, "glitch ignored");
    pulse2(185 * TD, 2200 * TD);
    chk(nst[1] == 0, "short pulse ignored");
    pulse2(215 * TD, 2200 * TD);
    chk(nst[1] == 0, "long pulse ignored");
    fork
      pulse2(1600 * TD, 2200 * TD);
      begin
        repeat (2200 * TD + 1560 * TD) @(posedge aclk);
        chk(dsh[1] === 1'b1, "stuck input dash");
      end
    join
    chk(nst[1] == 0 && flash2 === 1'b1, "stuck input no run");
    pulse2(205 * TD, 2200 * TD);
    chk(nst[1] == 1, "edge stroke runs");
    for (k = 0; k < 1000 && md[1] !== 1'b1; k++) @(posedge aclk);
    pulse2(200 * TD, 4);
    repeat (300 * TD) @(posedge aclk);
    chk(nst[1] == 1, "lockout after run");
    done2 = 1'b1;
  end

  initial begin
    int k;
    int n;
    int n0;
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_STAT, d, r);
    chk(d === 32'h0 && r === RESP_OKAY, "status after reset");
    wr(4'h8, 32'h1, r);
    chk(r === RESP_SLVERR, "unmapped write");
    rd(4'hC, d, r);
    chk(r === RESP_SLVERR && d === 32'h0, "unmapped read");
    wr(REG_CMD, 32'h1, r);
    wr(REG_CMD, 32'h2, r);
    rd(REG_STAT, d, r);
    chk(d[STAT_BUSY] === 1'b1 && d[STAT_REFUSED] === 1'b1, "refused while busy");
    rd(REG_CMD, d, r);
    chk(d[1:0] === 2'h1, "command readback");
    for (k = 0; k < 8000 && nst[0] == 0; k++) @(posedge aclk);
    repeat (20) @(posedge aclk);
    chk(link.status_line === 1'b0 && nst[0] == 1, "stroke run low");
    for (k = 0; k < 1000 && md[0] !== 1'b1; k++) @(posedge aclk);
    repeat (40) @(posedge aclk);
    chk(link.status_line === 1'b1, "run end high");
    for (k = 0; k < 4000; k++) begin
      rd(REG_STAT, d, r);
      if (d[STAT_BUSY] === 1'b0) break;
    end
    n0 = nst[0];
    wr(REG_CMD, 32'h2, r);
    for (k = 0; k < 60000 && nst[0] < n0 + int'(PREFILL_RUNS); k++) @(posedge aclk);
    repeat (400 * TD) @(posedge aclk);
    chk(nst[0] == n0 + int'(PREFILL_RUNS), "prefill run count");
    of <= 1'b1;
    uf <= 1'b1;
    repeat (8) @(posedge aclk);
    of <= 1'b0;
    uf <= 1'b0;
    repeat (20 * TD) @(posedge aclk);
    chk(link.status_line === 1'b0, "fault holds low");
    for (k = 0; k < 600 && red[0] !== 1'b1; k++) @(posedge aclk);
    chk(red[0] === 1'b1 && link.status_line === 1'b0, "fault red flash");
    wr(REG_CMD, 32'h3, r);
    for (k = 0; k < 10000 && clr[0] !== 1'b1; k++) @(posedge aclk);
    chk(clr[0] === 1'b1, "acknowledge clears");
    repeat (10 * TD) @(posedge aclk);
    chk(link.status_line === 1'b1, "high after acknowledge");
    cf <= 1'b1;
    // the first low half starts mid-tick, so the full high half after it is measured
    half(n);
    half(n);
    half(n);
    chk(n == int'(SQUARE_T) * TD, "square wave half");
    cf <= 1'b0;
    for (k = 0; k < 60000 && done2 !== 1'b1; k++) @(posedge aclk);
    pw <= 1'b0;
    repeat (10 * TD) @(posedge aclk);
    chk(link.status_line === 1'b0, "off holds low");
    pw <= 1'b1;
    pm <= 1'b0;
    n0 = nst[0];
    for (k = 0; k < 2000 && nst[0] == n0; k++) @(posedge aclk);
    chk(nst[0] == n0 + 1, "own timer run");
    close_out;
  end
endmodule
